// ### hdl/dbg_sink_pkg.sv
package dbg_sink_pkg;
    // port personality
    typedef enum logic [1:0] {
        ROLE_SINK,
        ROLE_SOURCE,
        ROLE_DUAL
    } port_role_e;

    // per-pin cc condition as seen by the comparators
    typedef enum logic [1:0] {
        CC_OPEN,
        CC_PULLUP,
        CC_PULLDOWN
    } cc_level_e;

    // cc termination request
    typedef enum logic [1:0] {
        TERM_NONE,
        TERM_PULLDOWN,
        TERM_PULLUP
    } cc_term_e;

    localparam int CLK_MHZ            = 250;
    // times in microseconds, duty cycle in percent
    localparam int T_ERR_RECOVERY_US  = 25000;
    localparam int T_PD_DEBOUNCE_US   = 10000;
    localparam int T_CC_DEBOUNCE_US   = 100000;
    localparam int T_DRP_US           = 75000;
    localparam int DC_SRC_DRP_PCT     = 50;
    localparam int T_DRP_TRANS_US     = 1000;
    // cycle counts and timer width
    localparam int ERR_RECOVERY_CYC   = T_ERR_RECOVERY_US * CLK_MHZ;
    localparam int PD_DEBOUNCE_CYC    = T_PD_DEBOUNCE_US * CLK_MHZ;
    localparam int CC_DEBOUNCE_CYC    = T_CC_DEBOUNCE_US * CLK_MHZ;
    localparam int DRP_OPEN_CYC       = (T_DRP_US * (100 - DC_SRC_DRP_PCT) / 100) * CLK_MHZ;
    localparam int DRP_TRANS_CYC      = T_DRP_TRANS_US * CLK_MHZ;
    localparam int TIMER_W            = 32;
endpackage

// ### hdl/dbg_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbg_timer_if #(parameter int W = 32);
    logic         restart;
    logic [W-1:0] limit;
    logic         done;
    modport ctrl (output restart, output limit, input done);
    modport tmr  (input restart, input limit, output done);
endinterface
`default_nettype wire

// ### hdl/dbg_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dbg_interval_timer #(
    parameter int W = 32
) (
    input  wire logic clk,
    input  wire logic nrst,
    dbg_timer_if.tmr  t
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (!nrst || t.restart) begin
            count_reg <= '0;
        end else if (count_reg < t.limit) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // count and limit only, not restart, so restart logic may read it without a loop
    assign t.done = (count_reg >= t.limit);
endmodule
`default_nettype wire

// ### hdl/debug_accessory_sink_attach_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module debug_accessory_sink_attach_fsm
    import dbg_sink_pkg::*;
#(
    parameter dbg_sink_pkg::port_role_e ROLE          = dbg_sink_pkg::ROLE_SINK,
    parameter bit                       HAS_ERR_RECOV = 1'b1,
    parameter bit                       HAS_DISABLED  = 1'b1,
    parameter int                       ERR_CYC       = dbg_sink_pkg::ERR_RECOVERY_CYC,
    parameter int                       PD_CYC        = dbg_sink_pkg::PD_DEBOUNCE_CYC,
    parameter int                       CC_CYC        = dbg_sink_pkg::CC_DEBOUNCE_CYC,
    parameter int                       DRP_OPEN      = dbg_sink_pkg::DRP_OPEN_CYC,
    parameter int                       DRP_TRANS     = dbg_sink_pkg::DRP_TRANS_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire dbg_sink_pkg::cc_level_e cc1_level,
    input  wire dbg_sink_pkg::cc_level_e cc2_level,
    input  wire logic                    vbus_present,
    input  wire logic                    recover_req,
    input  wire logic                    to_source_req,
    input  wire logic                    orientation_known,
    input  wire logic                    source_done,
    output logic                         vbus_drive_en,
    output logic                         vconn_drive_en,
    output dbg_sink_pkg::cc_term_e       cc1_term,
    output dbg_sink_pkg::cc_term_e       cc2_term,
    output logic                         debug_paths_en,
    output logic                         pd_allowed,
    output logic                         go_unattached_src,
    output logic                         go_try_src,
    output logic                         attached_snk,
    output logic                         in_disabled
);
    import dbg_sink_pkg::*;

    typedef enum logic [2:0] {
        ST_ERR_RECOVERY,
        ST_DISABLED,
        ST_UNATT_SNK,
        ST_ATTWAIT_SNK,
        ST_ATT_SNK,
        ST_SOURCE_SIDE
    } state_e;

    state_e state_reg;
    state_e state_next;
    logic   open_any;
    logic   both_pullup;
    logic   open_any_reg;
    logic   vbus_reg;
    logic   cc_change;
    logic   is_dual;
    logic   settled_done;
    logic   try_entry;

    dbg_timer_if #(.W(TIMER_W)) t_main();
    dbg_timer_if #(.W(TIMER_W)) t_trans();

    dbg_interval_timer #(.W(TIMER_W)) u_main (
        .clk  (clk),
        .nrst (nrst),
        .t    (t_main.tmr)
    );

    dbg_interval_timer #(.W(TIMER_W)) u_trans (
        .clk  (clk),
        .nrst (nrst),
        .t    (t_trans.tmr)
    );

    assign is_dual     = (ROLE == ROLE_DUAL);
    assign open_any    = (cc1_level == CC_OPEN) || (cc2_level == CC_OPEN);
    assign both_pullup = (cc1_level == CC_PULLUP) && (cc2_level == CC_PULLUP);

    // change tracking for debounce restart
    always_ff @(posedge clk) begin
        if (!nrst) begin
            open_any_reg <= 1'b0;
            vbus_reg     <= 1'b0;
        end else begin
            open_any_reg <= open_any;
            vbus_reg     <= vbus_present;
        end
    end

    assign cc_change = (open_any != open_any_reg) || (vbus_present != vbus_reg);
    // stale count ignored in the cycle of a change
    assign settled_done = t_main.done && !cc_change;

    // timer restart and limit per state
    always_comb begin
        t_main.restart  = (state_next != state_reg) || cc_change;
        t_main.limit    = TIMER_W'(CC_CYC);
        t_trans.restart = (state_next != state_reg) || !open_any;
        t_trans.limit   = TIMER_W'(DRP_OPEN + DRP_TRANS);
        unique case (state_reg)
            ST_ERR_RECOVERY: begin
                t_main.limit   = TIMER_W'(ERR_CYC);
                t_main.restart = (state_next != state_reg);
            end
            ST_UNATT_SNK: begin
                t_main.limit   = TIMER_W'(DRP_OPEN);
                t_main.restart = (state_next != state_reg) || !open_any;
            end
            ST_ATTWAIT_SNK: t_main.limit = open_any ? TIMER_W'(PD_CYC) : TIMER_W'(CC_CYC);
            default: t_main.limit = TIMER_W'(CC_CYC);
        endcase
    end

    always_comb begin
        state_next = state_reg;
        if (recover_req) begin
            if (HAS_ERR_RECOV) begin
                state_next = ST_ERR_RECOVERY;
            end else if (HAS_DISABLED) begin
                state_next = ST_DISABLED;
            end else begin
                state_next = (ROLE == ROLE_SINK) ? ST_UNATT_SNK : ST_SOURCE_SIDE;
            end
        end else begin
            unique case (state_reg)
                ST_ERR_RECOVERY: begin
                    if (t_main.done) begin
                        state_next = (ROLE == ROLE_SINK) ? ST_UNATT_SNK : ST_SOURCE_SIDE;
                    end
                end
                ST_DISABLED: begin
                    state_next = ST_DISABLED;
                end
                ST_UNATT_SNK: begin
                    if (both_pullup) begin
                        state_next = ST_ATTWAIT_SNK;
                    end else if (is_dual && (to_source_req || (open_any && t_main.done))) begin
                        state_next = ST_SOURCE_SIDE;
                    end
                end
                ST_ATTWAIT_SNK: begin
                    if (open_any && settled_done) begin
                        state_next = is_dual ? ST_SOURCE_SIDE : ST_UNATT_SNK;
                    end else if (!open_any && settled_done && vbus_present) begin
                        state_next = is_dual ? ST_SOURCE_SIDE : ST_ATT_SNK;
                    end
                end
                ST_ATT_SNK: begin
                    if (!vbus_present) begin
                        state_next = ST_UNATT_SNK;
                    end
                end
                ST_SOURCE_SIDE: begin
                    if (source_done) begin
                        state_next = ST_UNATT_SNK;
                    end
                end
                default: state_next = ST_UNATT_SNK;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_UNATT_SNK;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cc1_term <= TERM_PULLDOWN;
            cc2_term <= TERM_PULLDOWN;
        end else if (state_next == ST_ERR_RECOVERY || state_next == ST_DISABLED) begin
            cc1_term <= TERM_NONE;
            cc2_term <= TERM_NONE;
        end else if (state_next == ST_SOURCE_SIDE) begin
            cc1_term <= TERM_PULLUP;
            cc2_term <= TERM_PULLUP;
        end else begin
            cc1_term <= TERM_PULLDOWN;
            cc2_term <= TERM_PULLDOWN;
        end
    end

    // never drives vbus or vconn here
    assign vbus_drive_en  = 1'b0;
    assign vconn_drive_en = 1'b0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            debug_paths_en <= 1'b0;
            pd_allowed     <= 1'b0;
            attached_snk   <= 1'b0;
            in_disabled    <= 1'b0;
        end else begin
            debug_paths_en <= (state_next == ST_ATT_SNK);
            pd_allowed     <= (state_next == ST_ATT_SNK) && orientation_known;
            attached_snk   <= (state_next == ST_ATT_SNK);
            in_disabled    <= (state_next == ST_DISABLED);
        end
    end

    assign try_entry = (state_next == ST_SOURCE_SIDE) && (state_reg == ST_ATTWAIT_SNK) && !open_any && !recover_req;

    // handover requests to source-side states
    always_ff @(posedge clk) begin
        if (!nrst) begin
            go_unattached_src <= 1'b0;
            go_try_src        <= 1'b0;
        end else begin
            go_try_src        <= try_entry;
            go_unattached_src <= (state_next == ST_SOURCE_SIDE) && (state_reg != ST_SOURCE_SIDE) && !try_entry;
        end
    end

    // assertions and cover points
    property p_no_vconn;
        @(posedge clk) disable iff (!nrst) !vconn_drive_en && !vbus_drive_en;
    endproperty
    a_no_vconn: assert property (p_no_vconn) else $error("vbus or vconn driven");

    property p_err_release;
        @(posedge clk) disable iff (!nrst)
            (state_reg == ST_ERR_RECOVERY && $past(state_reg) == ST_ERR_RECOVERY)
            |-> (cc1_term == TERM_NONE && cc2_term == TERM_NONE);
    endproperty
    a_err_release: assert property (p_err_release) else $error("cc not released in recovery");

    property p_recover_enter;
        @(posedge clk) disable iff (!nrst)
            recover_req && HAS_ERR_RECOV |=> state_reg == ST_ERR_RECOVERY;
    endproperty
    a_recover_enter: assert property (p_recover_enter) else $error("recover not entered");

    property p_sink_terms;
        @(posedge clk) disable iff (!nrst)
            (state_reg == ST_ATTWAIT_SNK || state_reg == ST_ATT_SNK) && $stable(state_reg)
            |-> cc1_term == TERM_PULLDOWN && cc2_term == TERM_PULLDOWN;
    endproperty
    a_sink_terms: assert property (p_sink_terms) else $error("sink terminations missing");

    property p_attwait_entry;
        @(posedge clk) disable iff (!nrst)
            state_reg == ST_UNATT_SNK && both_pullup && !recover_req |=> state_reg == ST_ATTWAIT_SNK;
    endproperty
    a_attwait_entry: assert property (p_attwait_entry) else $error("attach-wait not entered");

    property p_drp_window;
        @(posedge clk) disable iff (!nrst) state_reg == ST_UNATT_SNK && is_dual |-> !t_trans.done;
    endproperty
    a_drp_window: assert property (p_drp_window) else $error("dual role exit window missed");

    property p_att_needs_vbus;
        @(posedge clk) disable iff (!nrst)
            state_reg == ST_ATT_SNK && $past(state_reg) == ST_ATTWAIT_SNK |-> $past(vbus_present) && !$past(open_any);
    endproperty
    a_att_needs_vbus: assert property (p_att_needs_vbus) else $error("attached without vbus");

    property p_vbus_loss;
        @(posedge clk) disable iff (!nrst)
            state_reg == ST_ATT_SNK && !vbus_present && !recover_req |=> state_reg == ST_UNATT_SNK ##1 !debug_paths_en;
    endproperty
    a_vbus_loss: assert property (p_vbus_loss) else $error("vbus loss not handled");

    property p_debug_paths;
        @(posedge clk) disable iff (!nrst) debug_paths_en |-> state_reg == ST_ATT_SNK;
    endproperty
    a_debug_paths: assert property (p_debug_paths) else $error("debug paths early");

    property p_pd_gate;
        @(posedge clk) disable iff (!nrst) pd_allowed |-> attached_snk && $past(orientation_known);
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("pd allowed too early");

    c_attach:  cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_ATTWAIT_SNK ##1 state_reg == ST_ATT_SNK);
    c_detach:  cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_ATT_SNK ##1 state_reg == ST_UNATT_SNK);
    c_recover: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_ERR_RECOVERY ##1 state_reg != ST_ERR_RECOVERY);
endmodule
`default_nettype wire

// ### test/target_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module target_port_model
    import dbg_sink_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic [1:0]               mode,
    output var  dbg_sink_pkg::cc_level_e  cc1,
    output var  dbg_sink_pkg::cc_level_e  cc2,
    output var  logic                     vbus
);
    // mode 0 detached, 1 pull-ups with vbus, 2 pull-ups no vbus, 3 mismatched with vbus
    // no vconn source
    initial begin
        cc1 = CC_OPEN;
        cc2 = CC_OPEN;
        vbus = 1'b0;
    end
    always @(posedge clk) begin
        case (mode)
            2'h1, 2'h2: begin
                cc1 <= CC_PULLUP;
                cc2 <= CC_PULLUP;
            end
            2'h3: begin
                cc1 <= CC_PULLUP;
                cc2 <= CC_PULLDOWN;
            end
            default: begin
                cc1 <= CC_OPEN;
                cc2 <= CC_OPEN;
            end
        endcase
        vbus <= (mode == 2'h1) || (mode == 2'h3);
    end
endmodule
`default_nettype wire

// ### test/debug_accessory_sink_attach_fsm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module debug_accessory_sink_attach_fsm_tb_top;
    import dbg_sink_pkg::*;
    localparam int ERR_C = 20;
    localparam int PD_C  = 20;
    localparam int CC_C  = 30;
    localparam int OPN_C = 40;
    localparam int TRN_C = 20;
    typedef struct {logic [1:0] mode; logic orient; int cyc; logic att; logic pd;} row_s;
    logic       clk, nrst, recover_req, to_source_req, orientation_known, source_done, vbus;
    logic       vbus_drv, vconn_drv, dbg_en, pd_ok, att, d_unsrc, d_try, d_att, nr_dis;
    logic [1:0] mode;
    cc_level_e  cc1, cc2;
    cc_term_e   t1, t2;
    row_s       rows[7];
    int         num_errors, cmp_count, unsrc_cnt, try_cnt, n, base;

    target_port_model u_far (.clk(clk), .mode(mode), .cc1(cc1), .cc2(cc2), .vbus(vbus));
    debug_accessory_sink_attach_fsm #(.ROLE(ROLE_SINK), .ERR_CYC(ERR_C), .PD_CYC(PD_C), .CC_CYC(CC_C),
        .DRP_OPEN(OPN_C), .DRP_TRANS(TRN_C)) u_dut (.clk(clk), .nrst(nrst), .cc1_level(cc1),
        .cc2_level(cc2), .vbus_present(vbus), .recover_req(recover_req), .to_source_req(to_source_req),
        .orientation_known(orientation_known), .source_done(source_done), .vbus_drive_en(vbus_drv),
        .vconn_drive_en(vconn_drv), .cc1_term(t1), .cc2_term(t2), .debug_paths_en(dbg_en),
        .pd_allowed(pd_ok), .go_unattached_src(), .go_try_src(), .attached_snk(att), .in_disabled());
    debug_accessory_sink_attach_fsm #(.ROLE(ROLE_DUAL), .ERR_CYC(ERR_C), .PD_CYC(PD_C), .CC_CYC(CC_C),
        .DRP_OPEN(OPN_C), .DRP_TRANS(TRN_C)) u_dut_dual (.clk(clk), .nrst(nrst), .cc1_level(cc1),
        .cc2_level(cc2), .vbus_present(vbus), .recover_req(recover_req), .to_source_req(to_source_req),
        .orientation_known(orientation_known), .source_done(source_done), .vbus_drive_en(),
        .vconn_drive_en(), .cc1_term(), .cc2_term(), .debug_paths_en(), .pd_allowed(),
        .go_unattached_src(d_unsrc), .go_try_src(d_try), .attached_snk(d_att), .in_disabled());
    debug_accessory_sink_attach_fsm #(.ROLE(ROLE_SINK), .HAS_ERR_RECOV(1'b0), .ERR_CYC(ERR_C), .PD_CYC(PD_C),
        .CC_CYC(CC_C), .DRP_OPEN(OPN_C), .DRP_TRANS(TRN_C)) u_dut_norec (.clk(clk), .nrst(nrst), .cc1_level(cc1),
        .cc2_level(cc2), .vbus_present(vbus), .recover_req(recover_req), .to_source_req(to_source_req),
        .orientation_known(orientation_known), .source_done(source_done), .vbus_drive_en(),
        .vconn_drive_en(), .cc1_term(), .cc2_term(), .debug_paths_en(), .pd_allowed(),
        .go_unattached_src(), .go_try_src(), .attached_snk(), .in_disabled(nr_dis));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        unsrc_cnt <= unsrc_cnt + int'(d_unsrc === 1'b1);
        try_cnt <= try_cnt + int'(d_try === 1'b1);
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic bit cond(input int which, input int b);
        case (which)
            0: return unsrc_cnt != b;
            1: return try_cnt != b;
            2: return att === 1'b1;
            default: return t1 === TERM_PULLDOWN;
        endcase
    endfunction
    task automatic wait_for(input int which, input int b, input int limit);
        n = 0;
        while (n < limit && !cond(which, b)) begin
            step(1);
            n++;
        end
    endtask
    task automatic pulse_done();
        source_done = 1'b1;
        step(1);
        source_done = 1'b0;
        step(2);
    endtask

    initial begin
        #(4 * 5000);
        num_errors++;
        conclude();
    end

    initial begin
        {nrst, recover_req, to_source_req, orientation_known, source_done} = 5'h00;
        {num_errors, cmp_count} = {2{32'h0000_0000}};
        mode = 2'h0;
        rows = '{'{2'h0, 1'b0, 10, 1'b0, 1'b0}, '{2'h3, 1'b1, 60, 1'b0, 1'b0}, '{2'h0, 1'b0, 10, 1'b0, 1'b0},
                 '{2'h1, 1'b1, 5, 1'b0, 1'b0}, '{2'h1, 1'b1, 40, 1'b1, 1'b1}, '{2'h1, 1'b0, 3, 1'b1, 1'b0},
                 '{2'h2, 1'b1, 3, 1'b0, 1'b0}};
        step(6);
        nrst = 1'b1;
        step(1);
        check({6'h00, t1, t2}, {6'h00, TERM_PULLDOWN, TERM_PULLDOWN});
        check({4'h0, att, dbg_en, pd_ok, vbus_drv}, 8'h00);
        check({7'h00, nr_dis}, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            mode = rows[i].mode;
            orientation_known = rows[i].orient;
            step(rows[i].cyc);
            check({7'h00, att}, {7'h00, rows[i].att});
            check({7'h00, dbg_en}, {7'h00, rows[i].att});
            check({7'h00, pd_ok}, {7'h00, rows[i].pd});
            check({6'h00, t1, t2}, {6'h00, TERM_PULLDOWN, TERM_PULLDOWN});
            check({6'h00, vbus_drv, vconn_drv}, 8'h00);
            $display("test row %0d done", i);
        end
        mode = 2'h1;
        wait_for(2, 0, CC_C + 10);
        check({7'h00, att}, 8'h01);
        base = unsrc_cnt;
        recover_req = 1'b1;
        step(1);
        recover_req = 1'b0;
        step(2);
        check({6'h00, t1, t2}, {6'h00, TERM_NONE, TERM_NONE});
        check({7'h00, att}, 8'h00);
        check({7'h00, nr_dis}, 8'h01);
        step(ERR_C - 5);
        check({6'h00, t1, t2}, {6'h00, TERM_NONE, TERM_NONE});
        wait_for(3, 0, 12);
        check({7'h00, t1 === TERM_PULLDOWN}, 8'h01);
        wait_for(0, base, 12);
        check({7'h00, unsrc_cnt != base}, 8'h01);
        $display("test recovery done");
        mode = 2'h0;
        step(2);
        pulse_done();
        base = unsrc_cnt;
        to_source_req = 1'b1;
        step(1);
        to_source_req = 1'b0;
        wait_for(0, base, 4);
        check({7'h00, unsrc_cnt != base}, 8'h01);
        pulse_done();
        base = unsrc_cnt;
        wait_for(0, base, OPN_C + TRN_C + 5);
        check({7'h00, unsrc_cnt != base}, 8'h01);
        check({7'h00, n >= OPN_C - 4}, 8'h01);
        $display("test dual open done");
        mode = 2'h2;
        step(2);
        pulse_done();
        step(4);
        base = unsrc_cnt;
        mode = 2'h0;
        wait_for(0, base, PD_C + 6);
        check({7'h00, unsrc_cnt != base}, 8'h01);
        mode = 2'h1;
        step(2);
        pulse_done();
        base = try_cnt;
        wait_for(1, base, CC_C + 10);
        check({7'h00, try_cnt != base}, 8'h01);
        check({7'h00, d_att}, 8'h00);
        $display("test dual attach done");
        conclude();
    end
endmodule
`default_nettype wire
